// ==== rtl/grc_pkg.sv ====
/*
  constants of the global reset controller: register addresses, field
  positions, reset values and hold timing.
  assumes a 40 MHz system clock and an 8-bit special function register port.
*/
// Overview of operation
// RQ1: any of seven sources asserts global reset
// RQ2: cause flags clear only by software write
// RQ3: power-up low holds reset, then 20ms
// RQ4: supply drop low holds reset, then 20ms
// RQ5: programming mode high holds reset, then 20ms
// RQ6: watchdog overflow gives 20ms reset
// RQ7: fetch overflow sampled on clock edge, 20ms
// RQ8: global reset clears fetch overflow indication
// RQ9: software reset only on value 0x55
// RQ10: debug request gives one-cycle reset, no stretch
// RQ11: flag bits: wdt,pwr,bo,fetch,prog,sw,dbg; 7 reserved
// RQ12: power-up loads flags with 0x02
// RQ13: other resets set only own flag
// RQ14: bit 3 disables brownout detector, default 1
// RQ15: software should enable detector early
// RQ16: reactivated source restarts hold; synchronous release
// RQ17: global reset clears software reset register
package grc_pkg;
  localparam logic [7:0] ADDR_SOFT_RST  = 8'h8E;
  localparam logic [7:0] ADDR_CAUSE     = 8'hD7;
  localparam logic [7:0] ADDR_ANA_PD    = 8'hFE;
  localparam logic [7:0] SOFT_RST_RESET = 8'h00;
  localparam logic [7:0] SOFT_RST_KEY   = 8'h55;
  localparam logic [7:0] ANA_PD_RESET   = 8'h1F;
  localparam logic [7:0] ANA_PD_MASK    = 8'h1D;
  localparam logic [7:0] CAUSE_POWERUP  = 8'h02;
  localparam logic [7:0] CAUSE_MASK     = 8'h7F;
  localparam int BIT_WDT   = 0;
  localparam int BIT_PWR   = 1;
  localparam int BIT_BO    = 2;
  localparam int BIT_FETCH = 3;
  localparam int BIT_PROG  = 4;
  localparam int BIT_SOFT  = 5;
  localparam int BIT_DEBUG = 6;
  localparam int BIT_ADC_OFF  = 0;
  localparam int BIT_XTAL_OFF = 2;
  localparam int BIT_BOR_OFF  = 3;
  localparam int BIT_LVD_OFF  = 4;
  localparam int CLK_HZ       = 40_000_000;
  localparam int HOLD_MS      = 20;
  localparam int HOLD_CYCLES  = CLK_HZ / 1000 * HOLD_MS;
  localparam int HOLD_W       = 20;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_HOLD  = 2'b01,
    ST_DEBUG = 2'b10
  } grc_state_t;
endpackage

// ==== rtl/grc_hold_timer.sv ====
/*
  hold timer: counts the stretch after the last active stretched source.
  assumes restart and level inputs already synchronous to clock_i.
*/
`timescale 1ns/100ps
`default_nettype none
module grc_hold_timer #(
  parameter logic [19:0] HOLD_CYCLES = 20'(grc_pkg::HOLD_CYCLES)
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // control
  input  wire logic restart_i,
  output logic      done_o
);
  typedef struct packed {
    logic [19:0] count;
    logic        done;
  } grc_tmr_t;
  grc_tmr_t st_ff;
  grc_tmr_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (restart_i) begin
      nxt_st.count = '0;                        // [RQ16]
      nxt_st.done  = 1'b0;
    end else if (!st_ff.done) begin
      if (st_ff.count >= HOLD_CYCLES - 20'h00001) begin
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.count = st_ff.count + 20'h00001;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_ff <= '{count: 20'h00000, done: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign done_o = st_ff.done;
endmodule
`default_nettype wire

// ==== rtl/grc_top.sv ====
/*
  global reset controller: merges seven reset sources into the chip reset,
  stretches it except on debug requests, records causes and holds analog power-down bits.
  assumes analog and programmer pins are asynchronous, watchdog, fetch and
  debug signals come from logic on clock_i, sfr writes last one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module grc_top #(
  parameter logic [19:0] HOLD_CYCLES = 20'(grc_pkg::HOLD_CYCLES)
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  // reset sources
  input  wire logic       power_up_reset_low_i,
  input  wire logic       supply_drop_reset_low_i,
  input  wire logic       prog_mode_i,
  input  wire logic       watchdog_overflow_i,
  input  wire logic       fetch_out_of_range_i,
  input  wire logic       debug_reset_low_i,
  // sfr port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // outputs
  output logic            global_reset_low_o,
  output logic            fetch_overflow_o,
  output logic            brownout_detector_off_o,
  output logic            low_voltage_detector_off_o,
  output logic            crystal_oscillator_off_o,
  output logic            converter_off_o
);
  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    grc_pkg::grc_state_t state;
    logic        rst_low;
    logic        fetch_ovf;
    logic [7:0]  soft_rst;
    logic [7:0]  cause;
    logic [7:0]  ana_pd;
    logic [7:0]  rdata;
    logic        pwr_seen;
  } grc_top_t;
  grc_top_t st_ff;
  grc_top_t nxt_st;
  logic pwr_act;
  logic bo_act;
  logic prog_act;
  logic soft_act;
  logic stretch_act;
  logic hold_done;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction
  // levels stay active for the whole time the source is asserted
  assign pwr_act  = !st_ff.sync2[0];                        // [RQ3]
  assign bo_act   = !st_ff.sync2[1];                        // [RQ4]
  assign prog_act = st_ff.sync2[2];                         // [RQ5]
  assign soft_act = hit(st_ff.soft_rst, grc_pkg::SOFT_RST_KEY); // [RQ9]
  assign stretch_act = pwr_act | bo_act | prog_act | watchdog_overflow_i
                     | st_ff.fetch_ovf | soft_act;          // [RQ1] [RQ6]
  grc_hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .restart_i (stretch_act),
    .done_o    (hold_done)
  );
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = {prog_mode_i, supply_drop_reset_low_i, power_up_reset_low_i};
    nxt_st.sync2 = st_ff.sync1;
    // fetch indication latched on the clock edge, cleared by the reset it causes
    if (fetch_out_of_range_i) begin
      nxt_st.fetch_ovf = 1'b1;                              // [RQ7]
    end else if (!st_ff.rst_low) begin
      nxt_st.fetch_ovf = 1'b0;                              // [RQ8]
    end
    // software writes first; hardware set wins afterwards
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        grc_pkg::ADDR_SOFT_RST: nxt_st.soft_rst = sfr_wdata_i;
        grc_pkg::ADDR_CAUSE:    nxt_st.cause = sfr_wdata_i & grc_pkg::CAUSE_MASK; // [RQ2]
        grc_pkg::ADDR_ANA_PD:   nxt_st.ana_pd = sfr_wdata_i & grc_pkg::ANA_PD_MASK; // [RQ14]
        default: ;
      endcase
    end
    if (!st_ff.rst_low) begin
      nxt_st.soft_rst = grc_pkg::SOFT_RST_RESET;            // [RQ17]
      nxt_st.ana_pd   = grc_pkg::ANA_PD_RESET & grc_pkg::ANA_PD_MASK; // [RQ14]
    end
    // cause flags; power-up replaces all, others set own bit only
    if (pwr_act) begin
      nxt_st.cause = grc_pkg::CAUSE_POWERUP;                // [RQ12]
    end else begin
      if (bo_act)              nxt_st.cause[grc_pkg::BIT_BO]    = 1'b1; // [RQ13] [RQ11]
      if (prog_act)            nxt_st.cause[grc_pkg::BIT_PROG]  = 1'b1;
      if (watchdog_overflow_i) nxt_st.cause[grc_pkg::BIT_WDT]   = 1'b1;
      if (st_ff.fetch_ovf)     nxt_st.cause[grc_pkg::BIT_FETCH] = 1'b1;
      if (soft_act)            nxt_st.cause[grc_pkg::BIT_SOFT]  = 1'b1;
      if (!debug_reset_low_i)  nxt_st.cause[grc_pkg::BIT_DEBUG] = 1'b1;
    end
    // global reset sequencing, released on a clock edge
    case (st_ff.state)
      grc_pkg::ST_RUN: begin
        if (stretch_act) begin
          nxt_st.state   = grc_pkg::ST_HOLD;                // [RQ1]
          nxt_st.rst_low = 1'b0;
        end else if (!debug_reset_low_i) begin
          nxt_st.state   = grc_pkg::ST_DEBUG;               // [RQ10]
          nxt_st.rst_low = 1'b0;
        end
      end
      grc_pkg::ST_HOLD: begin
        nxt_st.rst_low = 1'b0;
        if (hold_done && !stretch_act) begin
          nxt_st.state   = grc_pkg::ST_RUN;                 // [RQ16]
          nxt_st.rst_low = 1'b1;
        end
      end
      grc_pkg::ST_DEBUG: begin
        // single cycle low; a stretched source still takes over
        if (stretch_act) begin
          nxt_st.state   = grc_pkg::ST_HOLD;
          nxt_st.rst_low = 1'b0;
        end else begin
          nxt_st.state   = grc_pkg::ST_RUN;                 // [RQ10]
          nxt_st.rst_low = 1'b1;
        end
      end
      default: begin
        nxt_st.state   = grc_pkg::ST_HOLD;
        nxt_st.rst_low = 1'b0;
      end
    endcase
    case (sfr_addr_i)
      grc_pkg::ADDR_SOFT_RST: nxt_st.rdata = nxt_st.soft_rst;
      grc_pkg::ADDR_CAUSE:    nxt_st.rdata = nxt_st.cause;
      grc_pkg::ADDR_ANA_PD:   nxt_st.rdata = nxt_st.ana_pd;
      default:                nxt_st.rdata = 8'h00;
    endcase
    nxt_st.pwr_seen = st_ff.pwr_seen | pwr_act;
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_ff <= '{sync1: 3'h0, sync2: 3'h0, state: grc_pkg::ST_HOLD,
                 rst_low: 1'b0, fetch_ovf: 1'b0, soft_rst: 8'h00,
                 cause: grc_pkg::CAUSE_POWERUP,
                 ana_pd: grc_pkg::ANA_PD_RESET & grc_pkg::ANA_PD_MASK,
                 rdata: 8'h00, pwr_seen: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign sfr_rdata_o                = st_ff.rdata;
  assign global_reset_low_o         = st_ff.rst_low;
  assign fetch_overflow_o           = st_ff.fetch_ovf;
  assign brownout_detector_off_o    = st_ff.ana_pd[grc_pkg::BIT_BOR_OFF]; // [RQ14]
  assign low_voltage_detector_off_o = st_ff.ana_pd[grc_pkg::BIT_LVD_OFF];
  assign crystal_oscillator_off_o   = st_ff.ana_pd[grc_pkg::BIT_XTAL_OFF];
  assign converter_off_o            = st_ff.ana_pd[grc_pkg::BIT_ADC_OFF];
endmodule
`default_nettype wire

// ==== dv/grc_top_sva.sv ====
/* port checker of grc_top.
   assumes the hold count is handed down from the bound instance. */
`timescale 1ns/100ps
`default_nettype none
module grc_top_sva #(parameter logic [19:0] HOLD_CYCLES = 20'h14) (
  // watched ports
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       prog_mode_i,
  input wire logic       watchdog_overflow_i,
  input wire logic       fetch_out_of_range_i,
  input wire logic       debug_reset_low_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       global_reset_low_o,
  input wire logic       fetch_overflow_o,
  input wire logic       brownout_detector_off_o
);
  logic [19:0] low_ff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // low cycles so far; a repetition cannot reach the stretch length
  always_ff @(posedge clock_i)
    low_ff <= (reset_i || global_reset_low_o) ? 20'h0 : low_ff + 20'h1;
  property p_wdt; watchdog_overflow_i |=> !global_reset_low_o; endproperty
  a_wdt: assert property (p_wdt) else $error("no watchdog reset");
  property p_dbg; $fell(debug_reset_low_i) && global_reset_low_o ##1 debug_reset_low_i
    |-> !global_reset_low_o ##1 global_reset_low_o; endproperty
  a_dbg: assert property (p_dbg) else $error("debug reset not one cycle");
  property p_soft; sfr_wr_i && sfr_addr_i == 8'h8E && sfr_wdata_i == 8'h55
    && global_reset_low_o |=> ##1 !global_reset_low_o; endproperty
  a_soft: assert property (p_soft) else $error("no software reset");
  property p_prog; prog_mode_i [*4] |-> !global_reset_low_o; endproperty
  a_prog: assert property (p_prog) else $error("programming not in reset");
  property p_fetch; fetch_out_of_range_i && global_reset_low_o |=> ##1 !global_reset_low_o;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch reset");
  property p_fclr; (!global_reset_low_o && !fetch_out_of_range_i) [*3] |-> !fetch_overflow_o;
  endproperty
  a_fclr: assert property (p_fclr) else $error("fetch flag not cleared");
  property p_bor; !global_reset_low_o [*3] |-> brownout_detector_off_o; endproperty
  a_bor: assert property (p_bor) else $error("brownout detector on");
  property p_len; $rose(global_reset_low_o) |-> low_ff == 20'h1 || low_ff > HOLD_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("stretch too short");
endmodule
bind grc_top grc_top_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_grc_top_sva (.clock_i, .reset_i,
  .prog_mode_i, .watchdog_overflow_i, .fetch_out_of_range_i, .debug_reset_low_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .global_reset_low_o, .fetch_overflow_o,
  .brownout_detector_off_o);
`default_nettype wire

// ==== dv/grc_far_model.sv ====
/* far side: supervisor and programmer pins.
   assumes the bench asks for active levels. */
`timescale 1ns/100ps
`default_nettype none
module grc_far_model (
  // asked levels
  input  wire logic pwr_i,
  input  wire logic bo_i,
  input  wire logic prog_i,
  // pins
  output wire logic pwr_low_o,
  output wire logic bo_low_o,
  output wire logic prog_o
);
  // skew keeps pin edges off the clock edge, as real analog pins are
  assign #7 pwr_low_o = !pwr_i;
  assign #7 bo_low_o  = !bo_i;
  assign #7 prog_o    = prog_i;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
/* bench of grc_top: sfr reads and reset lengths scored from queues.
   assumes grc_far_model drives the asynchronous pins. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [19:0] HOLD = 20'h14;
  logic       clock_i, reset_i, pwr, bo, prog, wdt, fetch, dbg, wr, chk;
  logic [7:0] addr, wdata, g, lc, q_rd[$], q_len[$];
  wire logic  pl, bl, pm, rl;
  wire logic [7:0] rdata;
  wire logic [3:0] pdo;
  int         failures, n_compared;
  grc_far_model i_grc_far_model (.pwr_i(pwr), .bo_i(bo), .prog_i(prog),
    .pwr_low_o(pl), .bo_low_o(bl), .prog_o(pm));
  grc_top #(.HOLD_CYCLES(HOLD)) i_grc_top (.clock_i, .reset_i,
    .power_up_reset_low_i(pl), .supply_drop_reset_low_i(bl), .prog_mode_i(pm),
    .watchdog_overflow_i(wdt), .fetch_out_of_range_i(fetch), .debug_reset_low_i(dbg),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .global_reset_low_o(rl), .fetch_overflow_o(), .brownout_detector_off_o(pdo[3]),
    .low_voltage_detector_off_o(pdo[2]), .crystal_oscillator_off_o(pdo[1]),
    .converter_off_o(pdo[0]));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic cmp(input logic [7:0] e, input logic [7:0] o);
    n_compared++;
    if (e !== o) begin
      failures++;
      $display("BAD %0t exp %h got %h", $time, e, o);
    end
  endtask
  // 1ns after the edge lets registered outputs settle
  always @(posedge clock_i) begin
    #1;
    if (chk) cmp(q_rd.pop_front(), rdata);
    if (!rl) lc++;
    else if (lc != 0 && q_len.size() != 0) cmp(q_len.pop_front(), lc);
    if (rl || reset_i) lc = 8'h00;
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    q_rd.push_back(e);
    chk = 1'b1;
    @(negedge clock_i);
    // one note per read; a lingering strobe would pop an empty queue
    chk = 1'b0;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    chk = 1'b0;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock_i);
    wr = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rel;
    chk = 1'b0;
    repeat (3) @(negedge clock_i);
    for (int i = 0; i < 300 && !rl; i++) @(negedge clock_i);
    if (!rl) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic pulse(ref logic s);
    s = ~s;
    @(negedge clock_i);
    s = ~s;
    rel();
  endtask
  task automatic hold(ref logic s);
    s = 1'b1;
    repeat (6) @(negedge clock_i);
    s = 1'b0;
    rel();
  endtask
  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {reset_i, pwr, bo, prog, wdt, fetch, wr, chk} = 8'h80;
    dbg = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    lc = 8'h00;
    void'($urandom(84129));
    repeat (3) @(negedge clock_i);
    reset_i = 1'b0;
    rel();
    rd(8'hFE, 8'h1D);
    cmp(8'h0F, {4'h0, pdo});
    rd(8'h8E, 8'h00);
    rd(8'h3C, 8'h00);
    wrt(8'hFE, 8'h15);
    rd(8'hFE, 8'h15);
    cmp(8'h07, {4'h0, pdo});
    wrt(8'hD7, 8'hFF);
    rd(8'hD7, 8'h7F);
    wrt(8'hD7, 8'h00);
    rd(8'hD7, 8'h00);
    g = 8'($urandom_range(8, 2));
    q_len.push_back(8'(HOLD) + 8'h01 + g);
    wdt = 1'b1;
    @(negedge clock_i);
    wdt = 1'b0;
    repeat (g - 8'h01) @(negedge clock_i);
    pulse(wdt);
    rd(8'hD7, 8'h01);
    rd(8'hFE, 8'h1D);
    q_len.push_back(8'h01);
    pulse(dbg);
    rd(8'hD7, 8'h41);
    wrt(8'h8E, 8'h54);
    rd(8'h8E, 8'h54);
    rd(8'hD7, 8'h41);
    wrt(8'h8E, 8'h55);
    rel();
    rd(8'h8E, 8'h00);
    rd(8'hD7, 8'h61);
    pulse(fetch);
    rd(8'hD7, 8'h69);
    hold(prog);
    rd(8'hD7, 8'h79);
    hold(bo);
    rd(8'hD7, 8'h7D);
    hold(pwr);
    rd(8'hD7, 8'h02);
    finish_test();
  end
endmodule
`default_nettype wire
